// ===== pkg/io_ports_regs.svh
// Purpose: Addresses, reset values and timing counts of the I/O ports
// Assumes: 25 MHz ref_clk
// Notes: Active-low port data, so reset values de-assert everything
`ifndef IO_PORTS_REGS_SVH
`define IO_PORTS_REGS_SVH
// ==========================================
// I/O addresses
`define ADDR_CTRL_LOW 12'h321
`define ADDR_INTERNAL 12'h322
`define ADDR_STATUS_PRI 12'h323
`define ADDR_STATUS_SEC 12'h324
`define ADDR_CTRL_HIGH 12'h325
// ==========================================
// Field layout
`define CTRL_IN_BITS 6
`define CTRL_OUT_HIGH_BITS 4
`define ST_HEALTHY 0
`define ST_SEQUENCE 2
`define ST_DIAG 3
`define ST_TEMP 4
`define ST_PRESS 5
// ==========================================
// Reset and fixed values
`define OUT_RESET 8'hFF
`define OUT_HIGH_RESET 4'hF
`define IN_PAD_ONES 2'h3
`define UNMAPPED_READ 8'hFF
// ==========================================
// Timing
`define CLK_HZ 25000000
`define KEEPALIVE_MS 5000
`define KEEPALIVE_CYCLES (`KEEPALIVE_MS * (`CLK_HZ / 1000))
`define KEEPALIVE_CNT_W 27
`endif

// ===== pkg/io_ports_pkg.sv
// Purpose: Types of the instrument digital I/O port bank
// Assumes: io_ports_regs.svh holds the numbers
// Notes: Whole module state is one packed struct
`include "io_ports_regs.svh"
package io_ports_pkg;
   typedef logic [11:0] io_addr_t;
   typedef logic [7:0] io_byte_t;
   typedef logic [`CTRL_IN_BITS-1:0] ctrl_in_t;
   typedef logic [`CTRL_OUT_HIGH_BITS-1:0] ctrl_out_high_t;
   typedef logic [`KEEPALIVE_CNT_W-1:0] keepalive_cnt_t;
   typedef struct packed {
      ctrl_in_t inLowS1;
      ctrl_in_t inLowS2;
      ctrl_in_t inHighS1;
      ctrl_in_t inHighS2;
      io_byte_t internalS1;
      io_byte_t internalS2;
      logic keepaliveS1;
      logic keepaliveS2;
      logic keepaliveLast;
      io_byte_t outLow;
      ctrl_out_high_t outHigh;
      io_byte_t statusPri;
      io_byte_t statusSec;
      io_byte_t internalOut;
      io_byte_t rdData;
      keepalive_cnt_t keepaliveCnt;
      logic relayActive;
   } state_t;
endpackage : io_ports_pkg

// ===== hw/instrument_digital_io_ports.sv
// Purpose: Digital I/O port bank decoded in I/O space
// Assumes: ioRd and ioWr are one-cycle strobes on ref_clk
// Notes: Read data is registered, valid one cycle after ioRd
// Operation
// - Read 0x321 gives control inputs 1-6 active low, bits 6-7 one
// - Read 0x325 gives control inputs 7-12 active low, bits 6-7 one
// - Write 0x321 drives control outputs 1-8, zero asserts
// - Write 0x325 drives control outputs 9-12 from bits 0-3
// - Write 0x323 drives status outputs; bits 1, 6, 7 spare
// - Write 0x324 holds eight spare secondary status bits
// - Address 0x322 reads eight spare inputs, writes eight spare outputs
`timescale 1ns/1ps
`default_nettype none
`include "io_ports_regs.svh"

module instrument_digital_io_ports #(
   parameter int KeepaliveCycles = `KEEPALIVE_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // I/O space access
   input wire io_ports_pkg::io_addr_t ioAddr,
   input wire logic ioRd,
   input wire logic ioWr,
   input wire io_ports_pkg::io_byte_t ioWrData,
   output logic [7:0] ioRdData,
   // External control inputs, active low
   input wire io_ports_pkg::ctrl_in_t ctrlInLowN,
   input wire io_ports_pkg::ctrl_in_t ctrlInHighN,
   // Internal spare inputs
   input wire io_ports_pkg::io_byte_t internalIn,
   // External control outputs, active low
   output logic [7:0] ctrlOutLowN,
   output logic [3:0] ctrlOutHighN,
   // Primary status outputs
   output logic healthyIndicator,
   output logic sequenceRunningIndicator,
   output logic diagnosticsIndicator,
   output logic temperatureFaultIndicator,
   output logic pressureFaultIndicator,
   output logic [2:0] statusSpare,
   // Secondary status and internal spare outputs
   output logic [7:0] statusSecondary,
   output logic [7:0] internalOut,
   // Relay board keepalive
   input wire logic relayKeepalive,
   output logic relayBoardActive
);
   import io_ports_pkg::*;

   // ==========================================
   // State
   state_t cur_r;
   state_t cur_nxt;

   logic keepaliveEdge;
   logic keepaliveExpired;
   logic selLow;
   logic selInternal;
   logic selStatusPri;
   logic selStatusSec;
   logic selHigh;

   // ==========================================
   // Address decode
   assign selLow = (ioAddr == `ADDR_CTRL_LOW);
   assign selInternal = (ioAddr == `ADDR_INTERNAL);
   assign selStatusPri = (ioAddr == `ADDR_STATUS_PRI);
   assign selStatusSec = (ioAddr == `ADDR_STATUS_SEC);
   assign selHigh = (ioAddr == `ADDR_CTRL_HIGH);

   // ==========================================
   // Keepalive watch
   // Edge taken on synchronised copies only, never the first flop
   assign keepaliveEdge = cur_r.keepaliveS2 ^ cur_r.keepaliveLast;
   assign keepaliveExpired =
      (cur_r.keepaliveCnt >= keepalive_cnt_t'(KeepaliveCycles - 1));

   // ==========================================
   // Next state
   always_comb begin
      cur_nxt = cur_r;

      // Two-flop synchronisers for all pins
      cur_nxt.inLowS1 = ctrlInLowN;
      cur_nxt.inLowS2 = cur_r.inLowS1;
      cur_nxt.inHighS1 = ctrlInHighN;
      cur_nxt.inHighS2 = cur_r.inHighS1;
      cur_nxt.internalS1 = internalIn;
      cur_nxt.internalS2 = cur_r.internalS1;
      cur_nxt.keepaliveS1 = relayKeepalive;
      cur_nxt.keepaliveS2 = cur_r.keepaliveS1;
      cur_nxt.keepaliveLast = cur_r.keepaliveS2;

      // Register reads
      if (ioRd) begin
         if (selLow) begin
            cur_nxt.rdData = {`IN_PAD_ONES, cur_r.inLowS2};
         end else if (selHigh) begin
            cur_nxt.rdData = {`IN_PAD_ONES, cur_r.inHighS2};
         end else if (selInternal) begin
            cur_nxt.rdData = cur_r.internalS2;
         end else begin
            // Write-only status ports read as a floating bus
            cur_nxt.rdData = `UNMAPPED_READ;
         end
      end

      // Register writes
      if (ioWr) begin
         case (1'b1)
            selLow: begin
               cur_nxt.outLow = ioWrData;
            end
            selHigh: begin
               cur_nxt.outHigh = ioWrData[`CTRL_OUT_HIGH_BITS-1:0];
            end
            selStatusPri: begin
               cur_nxt.statusPri = ioWrData;
            end
            selStatusSec: begin
               cur_nxt.statusSec = ioWrData;
            end
            selInternal: begin
               cur_nxt.internalOut = ioWrData;
            end
            default: begin
               cur_nxt.outLow = cur_r.outLow;
            end
         endcase
      end

      // Relay keepalive timer
      // Board only wakes on a real edge, so a stuck line stays safe
      if (keepaliveEdge) begin
         cur_nxt.keepaliveCnt = '0;
         cur_nxt.relayActive = 1'b1;
      end else if (keepaliveExpired) begin
         cur_nxt.relayActive = 1'b0;
      end else begin
         cur_nxt.keepaliveCnt = cur_r.keepaliveCnt + keepalive_cnt_t'(1);
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cur_r <= '0;
         cur_r.inLowS1 <= '1;
         cur_r.inLowS2 <= '1;
         cur_r.inHighS1 <= '1;
         cur_r.inHighS2 <= '1;
         // Keepalive chain seeded at the idle pin level, so release is no edge
         cur_r.keepaliveS1 <= 1'b1;
         cur_r.keepaliveS2 <= 1'b1;
         cur_r.keepaliveLast <= 1'b1;
         cur_r.outLow <= `OUT_RESET;
         cur_r.outHigh <= `OUT_HIGH_RESET;
         cur_r.statusPri <= `OUT_RESET;
         cur_r.statusSec <= `OUT_RESET;
         cur_r.internalOut <= `OUT_RESET;
         cur_r.rdData <= `UNMAPPED_READ;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   // ==========================================
   // Outputs
   assign ioRdData = cur_r.rdData;
   assign ctrlOutLowN = cur_r.outLow;
   assign ctrlOutHighN = cur_r.outHigh;
   // Meaning of each status bit is set by controller firmware
   assign healthyIndicator = cur_r.statusPri[`ST_HEALTHY];
   assign sequenceRunningIndicator = cur_r.statusPri[`ST_SEQUENCE];
   assign diagnosticsIndicator = cur_r.statusPri[`ST_DIAG];
   assign temperatureFaultIndicator = cur_r.statusPri[`ST_TEMP];
   assign pressureFaultIndicator = cur_r.statusPri[`ST_PRESS];
   assign statusSpare = {cur_r.statusPri[7:6], cur_r.statusPri[1]};
   assign statusSecondary = cur_r.statusSec;
   assign internalOut = cur_r.internalOut;
   assign relayBoardActive = cur_r.relayActive;

endmodule : instrument_digital_io_ports
`default_nettype wire

// ===== bench/io_ports_checker_assertions.sv
// Purpose: Port-level checks of the I/O port bank
// Assumes: Strobes taken on ref_clk, answers one cycle later
// Notes: Inputs pass a 2-flop sync, so reads see pins from 2 edges back
`timescale 1ns/1ps
`default_nettype none
module io_ports_checker #(parameter int KeepaliveCycles = 50) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire io_ports_pkg::io_addr_t ioAddr,
   input wire logic ioRd,
   input wire logic ioWr,
   input wire io_ports_pkg::io_byte_t ioWrData,
   input wire logic [7:0] ioRdData,
   input wire io_ports_pkg::ctrl_in_t ctrlInLowN,
   input wire io_ports_pkg::ctrl_in_t ctrlInHighN,
   input wire logic [7:0] ctrlOutLowN,
   input wire logic [3:0] ctrlOutHighN,
   input wire logic healthyIndicator,
   input wire logic sequenceRunningIndicator,
   input wire logic diagnosticsIndicator,
   input wire logic temperatureFaultIndicator,
   input wire logic pressureFaultIndicator,
   input wire logic [2:0] statusSpare,
   input wire logic [7:0] statusSecondary,
   input wire logic [7:0] internalOut,
   input wire logic relayKeepalive,
   input wire logic relayBoardActive
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_read_low: assert property (ioRd && ioAddr == 12'h321 |=>
      ioRdData == {2'b11, $past(ctrlInLowN, 3)}) else $error("low inputs read wrong");
   a_read_high: assert property (ioRd && ioAddr == 12'h325 |=>
      ioRdData == {2'b11, $past(ctrlInHighN, 3)}) else $error("high inputs read wrong");
   a_write_low: assert property (ioWr && ioAddr == 12'h321 |=>
      ctrlOutLowN == $past(ioWrData)) else $error("low outputs wrong");
   a_write_high: assert property (ioWr && ioAddr == 12'h325 |=>
      ctrlOutHighN == $past(ioWrData[3:0])) else $error("high outputs wrong");
   a_status_primary: assert property (ioWr && ioAddr == 12'h323 |=>
      {statusSpare[2:1], pressureFaultIndicator, temperatureFaultIndicator,
      diagnosticsIndicator, sequenceRunningIndicator, statusSpare[0], healthyIndicator}
      == $past(ioWrData)) else $error("status outputs wrong");
   a_status_second: assert property (ioWr && ioAddr == 12'h324 |=>
      statusSecondary == $past(ioWrData)) else $error("secondary status wrong");
   a_spare_write: assert property (ioWr && ioAddr == 12'h322 |=>
      internalOut == $past(ioWrData)) else $error("spare outputs wrong");
   a_relay_wakes: assert property ($changed(relayKeepalive) |->
      ##[1:6] relayBoardActive) else $error("relay not woken");
endmodule : io_ports_checker
`default_nettype wire

// ===== bench/far_side_equipment.sv
// Purpose: External equipment on control and keepalive lines
// Assumes: Pins change on the ref_clk edge by non-blocking update
// Notes: keepPeriod of zero stops the keepalive, letting the relay expire
`timescale 1ns/1ps
`default_nettype none
module far_side_equipment (
   input wire logic ref_clk,
   input wire logic [5:0] setLow,
   input wire logic [5:0] setHigh,
   input wire logic [7:0] setInt,
   input wire logic [7:0] keepPeriod,
   output var io_ports_pkg::ctrl_in_t ctrlInLowN,
   output var io_ports_pkg::ctrl_in_t ctrlInHighN,
   output var io_ports_pkg::io_byte_t internalIn,
   output var logic relayKeepalive
);
   int cnt = 0;
   initial {ctrlInLowN, ctrlInHighN, internalIn, relayKeepalive} = '1;
   always @(posedge ref_clk) begin
      ctrlInLowN <= setLow;
      ctrlInHighN <= setHigh;
      internalIn <= setInt;
      cnt <= (keepPeriod == 8'h00 || cnt >= keepPeriod) ? 0 : cnt + 1;
      if (keepPeriod != 8'h00 && cnt >= keepPeriod) relayKeepalive <= ~relayKeepalive;
   end
endmodule : far_side_equipment
`default_nettype wire

// ===== bench/instrument_digital_io_ports_bench.sv
// Purpose: Self-checking bench of the I/O port bank
// Assumes: Checker bound to the design, far side modelled
// Notes: Keepalive count shortened so the run stays brief
`timescale 1ns/1ps
`default_nettype none
module instrument_digital_io_ports_bench;
   import io_ports_pkg::*;
   localparam int KeepaliveCycles = 50;
   logic ref_clk = 0, nrst = 0, ioRd = 0, ioWr = 0, relayKeepalive, relayBoardActive;
   io_addr_t ioAddr = '0, a;
   io_byte_t ioWrData = '0, d, internalIn, ioRdData, ctrlOutLowN, statusSecondary, internalOut;
   ctrl_in_t ctrlInLowN, ctrlInHighN;
   logic [5:0] setLow = '1, setHigh = '1;
   logic [7:0] setInt = '1, keepPeriod = '0;
   logic [3:0] ctrlOutHighN;
   logic [2:0] statusSpare;
   logic healthyIndicator, sequenceRunningIndicator, diagnosticsIndicator;
   logic temperatureFaultIndicator, pressureFaultIndicator;
   logic [7:0] wm [int];
   int errorCnt = 0, cmpCount = 0, r;
   wire logic [7:0] stAll = {statusSpare[2:1], pressureFaultIndicator, temperatureFaultIndicator,
      diagnosticsIndicator, sequenceRunningIndicator, statusSpare[0], healthyIndicator};
   instrument_digital_io_ports #(.KeepaliveCycles(KeepaliveCycles)) u_dut (.*);
   far_side_equipment u_far (.*);
   initial forever #20 ref_clk = ~ref_clk;
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      cmpCount++;
      if (e !== g) begin
         errorCnt++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic chkOut();
      chk("ctrlOutLowN", wm[12'h321], ctrlOutLowN);
      chk("ctrlOutHighN", wm[12'h325] & 8'h0F, {4'h0, ctrlOutHighN});
      chk("status", wm[12'h323], stAll);
      chk("statusSecondary", wm[12'h324], statusSecondary);
      chk("internalOut", wm[12'h322], internalOut);
   endtask : chkOut
   // One strobe held a full cycle; the write model follows mapped writes
   task automatic acc(logic w, io_addr_t ad, io_byte_t dt);
      @(posedge ref_clk);
      #1;
      ioAddr = ad;
      ioWrData = dt;
      ioWr = w;
      ioRd = !w;
      @(posedge ref_clk);
      #1;
      ioWr = 0;
      ioRd = 0;
      if (w && wm.exists(ad)) wm[ad] = dt;
   endtask : acc
   function automatic logic [7:0] rexp(io_addr_t ad);
      if (ad == 12'h321) return {2'b11, setLow};
      if (ad == 12'h325) return {2'b11, setHigh};
      if (ad == 12'h322) return setInt;
      return 8'hFF;
   endfunction : rexp
   task automatic testDone();
      if (errorCnt == 0 && cmpCount > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : testDone
   initial begin
      r = $urandom(14119);
      for (int i = 12'h321; i <= 12'h325; i++) wm[i] = 8'hFF;
      repeat (2) @(posedge ref_clk);
      #1 nrst = 1;
      chkOut();
      chk("relayBoardActive", 8'h00, {7'h0, relayBoardActive});
      chk("ioRdData", 8'hFF, ioRdData);
      // Unmapped 0x320 and 0x326 included; reads of write-only ports give ones
      repeat (40) begin
         setLow = 6'($urandom);
         setHigh = 6'($urandom);
         setInt = 8'($urandom);
         repeat (4) @(posedge ref_clk);
         a = 12'h320 + 12'($urandom_range(6));
         d = 8'($urandom);
         acc(1, a, d);
         chkOut();
         acc(0, a, 8'h00);
         chk("ioRdData", rexp(a), ioRdData);
      end
      acc(1, 12'h323, 8'h3A);
      chk("healthyIndicator", 8'h00, {7'h0, healthyIndicator});
      chk("sequenceRunningIndicator", 8'h00, {7'h0, sequenceRunningIndicator});
      chk("diagnosticsIndicator", 8'h01, {7'h0, diagnosticsIndicator});
      chk("temperatureFaultIndicator", 8'h01, {7'h0, temperatureFaultIndicator});
      chk("pressureFaultIndicator", 8'h01, {7'h0, pressureFaultIndicator});
      chk("relayBoardActive", 8'h00, {7'h0, relayBoardActive});
      keepPeriod = 8'd20;
      repeat (100) @(posedge ref_clk);
      chk("relayBoardActive", 8'h01, {7'h0, relayBoardActive});
      keepPeriod = 8'h00;
      repeat (KeepaliveCycles + 30) @(posedge ref_clk);
      chk("relayBoardActive", 8'h00, {7'h0, relayBoardActive});
      testDone();
   end
endmodule : instrument_digital_io_ports_bench
bind instrument_digital_io_ports io_ports_checker #(.KeepaliveCycles(KeepaliveCycles)) u_chk (.*);
`default_nettype wire
